// >>> rtl/coef_bank.v
// coefficient bank slice: channel A ninth tap and channel B taps one to four
// Operation
// [RULE1] each weight is 12-bit signed two's complement; bits 15:12 reserved
// [RULE2] dual mode: channel A ninth-tap register weights channel A tap nine
// [RULE3] single mode: same register weights tap nine of the combined filter
// [RULE4] dual mode: channel B first register weights channel B tap one
// [RULE5] dual mode: channel B second register weights channel B tap two
// [RULE6] dual mode: channel B third register weights channel B tap three
// [RULE7] dual mode: channel B fourth register weights channel B tap four
// [RULE8] filter has nine taps; centre weight 18 bits, outer weights 12 bits
// [RULE9] weights reset to zero; written coefficient bits read back unchanged
`timescale 1ns/1ps
`include "coef_bank_defines.vh"

module coef_bank #(
  parameter ADDR_W       = 15,
  parameter OUTER_WIDTH  = `OUTER_WIDTH,
  parameter CENTRE_WIDTH = `CENTRE_WIDTH,
  parameter TAP_COUNT    = `TAP_COUNT
) (
  input  wire                    MCLK_I,
  input  wire                    RST_N_I,
  input  wire                    SINGLE_MODE_I,
  input  wire [ADDR_W-1:0]       ADDR_I,
  input  wire                    WR_EN_I,
  input  wire                    RD_EN_I,
  input  wire [7:0]              WDATA_I,
  output reg  [7:0]              RDATA_O,
  output reg                     RVALID_O,
  output reg  [CENTRE_WIDTH-1:0] CHAN_A_TAP9_WEIGHT_O,
  output reg  [CENTRE_WIDTH-1:0] COMB_TAP9_WEIGHT_O,
  output reg  [CENTRE_WIDTH-1:0] CHAN_B_TAP1_WEIGHT_O,
  output reg  [CENTRE_WIDTH-1:0] CHAN_B_TAP2_WEIGHT_O,
  output reg  [CENTRE_WIDTH-1:0] CHAN_B_TAP3_WEIGHT_O,
  output reg  [CENTRE_WIDTH-1:0] CHAN_B_TAP4_WEIGHT_O
);

  localparam WORDS = 5;

  wire [WORDS-1:0]             hit_lo;
  wire [WORDS-1:0]             hit_hi;
  wire [8*WORDS-1:0]           rd_bytes;
  wire [OUTER_WIDTH*WORDS-1:0] weights;
  wire                         rd_hit;

  reg  [7:0]                   rdata_next;
  reg  [CENTRE_WIDTH-1:0]      a_tap9_next;
  reg  [CENTRE_WIDTH-1:0]      comb_tap9_next;
  reg  [CENTRE_WIDTH-1:0]      b_tap1_next;
  reg  [CENTRE_WIDTH-1:0]      b_tap2_next;
  reg  [CENTRE_WIDTH-1:0]      b_tap3_next;
  reg  [CENTRE_WIDTH-1:0]      b_tap4_next;
  integer                      k;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function [ADDR_W-1:0] word_base;
    input integer idx;
    begin
      case (idx)
        0:       word_base = `CHAN_A_TAP_NINE_WEIGHT_OFS;
        1:       word_base = `CHAN_B_TAP_ONE_WEIGHT_OFS;
        2:       word_base = `CHAN_B_TAP_TWO_WEIGHT_OFS;
        3:       word_base = `CHAN_B_TAP_THREE_WEIGHT_OFS;
        default: word_base = `CHAN_B_TAP_FOUR_WEIGHT_OFS;
      endcase
    end
  endfunction

  // outer weights are sign-extended to the centre-tap width so that all
  // nine products line up in the accumulator without a second alignment
  function [CENTRE_WIDTH-1:0] to_centre;
    input [OUTER_WIDTH-1:0] w;
    begin
      to_centre = {{(CENTRE_WIDTH-OUTER_WIDTH){w[OUTER_WIDTH-1]}}, w}; // [RULE8] [RULE1]
    end
  endfunction

  // ----------------------------------------------------------------
  // coefficient storage
  // ----------------------------------------------------------------
  coef_word_reg #(
    .ADDR_W (ADDR_W),
    .WIDTH  (OUTER_WIDTH)
  ) chan_a_tap_nine_weight_inst (
    .MCLK_I      (MCLK_I),
    .RST_N_I     (RST_N_I),
    .base_addr_i (word_base(0)),
    .addr_i      (ADDR_I),
    .wr_en_i     (WR_EN_I),
    .wdata_i     (WDATA_I),
    .hit_lo_o    (hit_lo[0]),
    .hit_hi_o    (hit_hi[0]),
    .rd_byte_o   (rd_bytes[8*0 +: 8]),
    .weight_o    (weights[OUTER_WIDTH*0 +: OUTER_WIDTH])
  );

  coef_word_reg #(
    .ADDR_W (ADDR_W),
    .WIDTH  (OUTER_WIDTH)
  ) chan_b_tap_one_weight_inst (
    .MCLK_I      (MCLK_I),
    .RST_N_I     (RST_N_I),
    .base_addr_i (word_base(1)),
    .addr_i      (ADDR_I),
    .wr_en_i     (WR_EN_I),
    .wdata_i     (WDATA_I),
    .hit_lo_o    (hit_lo[1]),
    .hit_hi_o    (hit_hi[1]),
    .rd_byte_o   (rd_bytes[8*1 +: 8]),
    .weight_o    (weights[OUTER_WIDTH*1 +: OUTER_WIDTH])
  );

  coef_word_reg #(
    .ADDR_W (ADDR_W),
    .WIDTH  (OUTER_WIDTH)
  ) chan_b_tap_two_weight_inst (
    .MCLK_I      (MCLK_I),
    .RST_N_I     (RST_N_I),
    .base_addr_i (word_base(2)),
    .addr_i      (ADDR_I),
    .wr_en_i     (WR_EN_I),
    .wdata_i     (WDATA_I),
    .hit_lo_o    (hit_lo[2]),
    .hit_hi_o    (hit_hi[2]),
    .rd_byte_o   (rd_bytes[8*2 +: 8]),
    .weight_o    (weights[OUTER_WIDTH*2 +: OUTER_WIDTH])
  );

  coef_word_reg #(
    .ADDR_W (ADDR_W),
    .WIDTH  (OUTER_WIDTH)
  ) chan_b_tap_three_weight_inst (
    .MCLK_I      (MCLK_I),
    .RST_N_I     (RST_N_I),
    .base_addr_i (word_base(3)),
    .addr_i      (ADDR_I),
    .wr_en_i     (WR_EN_I),
    .wdata_i     (WDATA_I),
    .hit_lo_o    (hit_lo[3]),
    .hit_hi_o    (hit_hi[3]),
    .rd_byte_o   (rd_bytes[8*3 +: 8]),
    .weight_o    (weights[OUTER_WIDTH*3 +: OUTER_WIDTH])
  );

  coef_word_reg #(
    .ADDR_W (ADDR_W),
    .WIDTH  (OUTER_WIDTH)
  ) chan_b_tap_four_weight_inst (
    .MCLK_I      (MCLK_I),
    .RST_N_I     (RST_N_I),
    .base_addr_i (word_base(4)),
    .addr_i      (ADDR_I),
    .wr_en_i     (WR_EN_I),
    .wdata_i     (WDATA_I),
    .hit_lo_o    (hit_lo[4]),
    .hit_hi_o    (hit_hi[4]),
    .rd_byte_o   (rd_bytes[8*4 +: 8]),
    .weight_o    (weights[OUTER_WIDTH*4 +: OUTER_WIDTH])
  );

  // ----------------------------------------------------------------
  // read path; unmapped addresses return zero
  // ----------------------------------------------------------------
  assign rd_hit = |{hit_lo, hit_hi};

  // at most one byte lane hits, so or-ing the lanes is a mux with no priority chain
  always @* begin
    rdata_next = `READ_ZERO;
    if (rd_hit) begin
      for (k = 0; k < WORDS; k = k + 1) begin
        rdata_next = rdata_next | rd_bytes[8*k +: 8]; // [RULE9]
      end
    end
  end

  // read data hold until the next read so the host may collect them late
  always @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      RDATA_O  <= `READ_ZERO;
      RVALID_O <= 1'b0;
    end else begin
      RVALID_O <= RD_EN_I;
      if (RD_EN_I) begin
        RDATA_O <= rdata_next; // [RULE9]
      end
    end
  end

  // ----------------------------------------------------------------
  // tap mapping by channel mode
  // ----------------------------------------------------------------
  // channel B taps are held at zero in single mode: that filter is idle
  // and a zero weight keeps it from injecting stale coefficients
  always @* begin
    a_tap9_next    = {CENTRE_WIDTH{1'b0}};
    comb_tap9_next = {CENTRE_WIDTH{1'b0}};
    b_tap1_next    = {CENTRE_WIDTH{1'b0}};
    b_tap2_next    = {CENTRE_WIDTH{1'b0}};
    b_tap3_next    = {CENTRE_WIDTH{1'b0}};
    b_tap4_next    = {CENTRE_WIDTH{1'b0}};
    if (SINGLE_MODE_I) begin
      comb_tap9_next = to_centre(weights[0 +: OUTER_WIDTH]); // [RULE3]
    end else begin
      a_tap9_next = to_centre(weights[0 +: OUTER_WIDTH]); // [RULE2]
      b_tap1_next = to_centre(weights[OUTER_WIDTH*1 +: OUTER_WIDTH]); // [RULE4]
      b_tap2_next = to_centre(weights[OUTER_WIDTH*2 +: OUTER_WIDTH]); // [RULE5]
      b_tap3_next = to_centre(weights[OUTER_WIDTH*3 +: OUTER_WIDTH]); // [RULE6]
      b_tap4_next = to_centre(weights[OUTER_WIDTH*4 +: OUTER_WIDTH]); // [RULE7]
    end
  end

  always @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      CHAN_A_TAP9_WEIGHT_O <= {CENTRE_WIDTH{1'b0}};
      COMB_TAP9_WEIGHT_O   <= {CENTRE_WIDTH{1'b0}};
      CHAN_B_TAP1_WEIGHT_O <= {CENTRE_WIDTH{1'b0}};
      CHAN_B_TAP2_WEIGHT_O <= {CENTRE_WIDTH{1'b0}};
      CHAN_B_TAP3_WEIGHT_O <= {CENTRE_WIDTH{1'b0}};
      CHAN_B_TAP4_WEIGHT_O <= {CENTRE_WIDTH{1'b0}};
    end else begin
      CHAN_A_TAP9_WEIGHT_O <= a_tap9_next;
      COMB_TAP9_WEIGHT_O   <= comb_tap9_next;
      CHAN_B_TAP1_WEIGHT_O <= b_tap1_next;
      CHAN_B_TAP2_WEIGHT_O <= b_tap2_next;
      CHAN_B_TAP3_WEIGHT_O <= b_tap3_next;
      CHAN_B_TAP4_WEIGHT_O <= b_tap4_next;
    end
  end

endmodule // coef_bank

// >>> rtl/coef_bank_defines.vh
// register offsets, field layout and reset values of the equalizer filter coefficient bank
`ifndef COEF_BANK_DEFINES_VH
`define COEF_BANK_DEFINES_VH

// ----------------------------------------------------------------
// register byte offsets (low byte; high byte sits at offset + 1)
// ----------------------------------------------------------------
`define CHAN_A_TAP_NINE_WEIGHT_OFS  15'h0429
`define CHAN_B_TAP_ONE_WEIGHT_OFS   15'h0448
`define CHAN_B_TAP_TWO_WEIGHT_OFS   15'h044A
`define CHAN_B_TAP_THREE_WEIGHT_OFS 15'h044C
`define CHAN_B_TAP_FOUR_WEIGHT_OFS  15'h044E

// ----------------------------------------------------------------
// field layout and reset values
// ----------------------------------------------------------------
`define WEIGHT_MSB        11
`define WEIGHT_LSB        0
`define WEIGHT_HI_BYTE_MSB 3
`define WEIGHT_RESET      12'h000
`define READ_ZERO         8'h00

// ----------------------------------------------------------------
// filter geometry
// ----------------------------------------------------------------
`define TAP_COUNT         9
`define OUTER_WIDTH       12
`define CENTRE_WIDTH      18

`endif

// >>> rtl/coef_word_reg.v
// one 12-bit signed coefficient register reached as two byte addresses
`timescale 1ns/1ps
`include "coef_bank_defines.vh"

module coef_word_reg #(
  parameter ADDR_W = 15,
  parameter WIDTH  = `OUTER_WIDTH
) (
  input  wire              MCLK_I,
  input  wire              RST_N_I,
  input  wire [ADDR_W-1:0] base_addr_i,
  input  wire [ADDR_W-1:0] addr_i,
  input  wire              wr_en_i,
  input  wire [7:0]        wdata_i,
  output wire              hit_lo_o,
  output wire              hit_hi_o,
  output wire [7:0]        rd_byte_o,
  output wire [WIDTH-1:0]  weight_o
);

  reg  [WIDTH-1:0] weight_reg;
  reg  [WIDTH-1:0] weight_next;

  assign hit_lo_o = (addr_i == base_addr_i);
  assign hit_hi_o = (addr_i == base_addr_i + {{(ADDR_W-1){1'b0}}, 1'b1});

  // ----------------------------------------------------------------
  // byte writes; reserved bits 15:12 are dropped and read as zero
  // ----------------------------------------------------------------
  always @* begin
    weight_next = weight_reg;
    if (wr_en_i && hit_lo_o) begin
      weight_next[7:0] = wdata_i; // [RULE9]
    end
    if (wr_en_i && hit_hi_o) begin
      weight_next[WIDTH-1:8] = wdata_i[`WEIGHT_HI_BYTE_MSB:0]; // [RULE1]
    end
  end

  always @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      weight_reg <= `WEIGHT_RESET; // [RULE9]
    end else begin
      weight_reg <= weight_next;
    end
  end

  assign rd_byte_o = hit_lo_o ? weight_reg[7:0] :
                     hit_hi_o ? {4'h0, weight_reg[WIDTH-1:8]} : `READ_ZERO; // [RULE1]
  assign weight_o  = weight_reg;

endmodule // coef_word_reg

// >>> test/coef_bank_chk.sv
// concurrent checks on the coefficient bank ports
`timescale 1ns/1ps
module coef_bank_chk #(parameter ADDR_W = 15, parameter CENTRE_WIDTH = 18) (
  input wire                    MCLK_I, RST_N_I, SINGLE_MODE_I, WR_EN_I, RD_EN_I, RVALID_O,
  input wire [ADDR_W-1:0]       ADDR_I,
  input wire [7:0]              WDATA_I, RDATA_O,
  input wire [CENTRE_WIDTH-1:0] CHAN_A_TAP9_WEIGHT_O, COMB_TAP9_WEIGHT_O, CHAN_B_TAP1_WEIGHT_O,
  input wire [CENTRE_WIDTH-1:0] CHAN_B_TAP2_WEIGHT_O, CHAN_B_TAP3_WEIGHT_O, CHAN_B_TAP4_WEIGHT_O
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);
  sequence s_quiet; !WR_EN_I && !SINGLE_MODE_I; endsequence
  sequence s_to_single; s_quiet [*2] ##1 (SINGLE_MODE_I && !WR_EN_I); endsequence
  sequence s_wr_b1; WR_EN_I && ADDR_I == 15'h0448 && !SINGLE_MODE_I; endsequence
  property p_rd_ans; RD_EN_I |=> RVALID_O; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_rd_idle; !RD_EN_I |=> !RVALID_O && $stable(RDATA_O); endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data moved");
  property p_hi; RD_EN_I && ADDR_I inside {15'h042A, 15'h0449, 15'h044B, 15'h044D, 15'h044F}
    |=> RDATA_O[7:4] == 4'h0; endproperty
  a_hi: assert property (p_hi) else $error("reserved bits read nonzero");
  property p_sx; CHAN_B_TAP1_WEIGHT_O[17:12] == {6{CHAN_B_TAP1_WEIGHT_O[11]}}; endproperty
  a_sx: assert property (p_sx) else $error("weight not sign extended");
  property p_single; SINGLE_MODE_I |=> (CHAN_A_TAP9_WEIGHT_O | CHAN_B_TAP1_WEIGHT_O | CHAN_B_TAP2_WEIGHT_O
    | CHAN_B_TAP3_WEIGHT_O | CHAN_B_TAP4_WEIGHT_O) == 18'h0_0000; endproperty
  a_single: assert property (p_single) else $error("dual taps live in single mode");
  property p_dual; !SINGLE_MODE_I |=> COMB_TAP9_WEIGHT_O == 18'h0_0000; endproperty
  a_dual: assert property (p_dual) else $error("combined tap live in dual mode");
  property p_swap; s_to_single |=> COMB_TAP9_WEIGHT_O == $past(CHAN_A_TAP9_WEIGHT_O); endproperty
  a_swap: assert property (p_swap) else $error("tap nine lost on mode change");
  property p_wr; s_wr_b1 ##1 (!SINGLE_MODE_I && !WR_EN_I)
    |=> CHAN_B_TAP1_WEIGHT_O[7:0] == $past(WDATA_I, 2); endproperty
  a_wr: assert property (p_wr) else $error("tap one weight not updated");
endmodule // coef_bank_chk

// >>> test/coef_bank_tb.sv
// self-checking bench for the coefficient bank
`timescale 1ns/1ps
module coef_bank_tb;
  reg         clk = 0, rst_n = 0, single = 0, wr_en = 0, rd_en = 0;
  reg  [14:0] addr = 0;
  reg  [7:0]  wdata = 0;
  wire [7:0]  rdata;
  wire        rvalid;
  wire [17:0] a9, c9, b1, b2, b3, b4;
  integer     error_cnt = 0, tests_run = 0, cyc = 0, i;
  reg  [14:0] offs [0:4] = '{15'h0429, 15'h0448, 15'h044A, 15'h044C, 15'h044E};
  reg  [11:0] v [0:4] = '{12'h000, 12'h000, 12'h000, 12'h000, 12'h000};
  coef_bank coef_bank_inst (.MCLK_I(clk), .RST_N_I(rst_n), .SINGLE_MODE_I(single), .ADDR_I(addr),
    .WR_EN_I(wr_en), .RD_EN_I(rd_en), .WDATA_I(wdata), .RDATA_O(rdata), .RVALID_O(rvalid),
    .CHAN_A_TAP9_WEIGHT_O(a9), .COMB_TAP9_WEIGHT_O(c9), .CHAN_B_TAP1_WEIGHT_O(b1),
    .CHAN_B_TAP2_WEIGHT_O(b2), .CHAN_B_TAP3_WEIGHT_O(b3), .CHAN_B_TAP4_WEIGHT_O(b4));
  initial forever #2.5 clk = ~clk;
  // the whole run needs about a hundred cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt = error_cnt + 1;
      tally_and_finish;
    end
  end
  function [17:0] sx(input [11:0] w);
    sx = {{6{w[11]}}, w};
  endfunction
  task chk(input string nm, input [17:0] e, input [17:0] g);
    begin
      tests_run = tests_run + 1;
      if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task wr(input [14:0] a, input [7:0] d);
    begin
      @(negedge clk);
      addr = a;
      wdata = d;
      wr_en = 1;
      @(negedge clk);
      wr_en = 0;
    end
  endtask
  task rd(input [14:0] a, input [7:0] e);
    begin
      @(negedge clk);
      addr = a;
      rd_en = 1;
      @(negedge clk);
      rd_en = 0;
      chk("rvalid", 18'h0_0001, {17'h0_0000, rvalid});
      chk("rdata", {10'h000, e}, {10'h000, rdata});
    end
  endtask
  task chk_outs(input s);
    begin
      chk("a9", s ? 18'h0_0000 : sx(v[0]), a9);
      chk("c9", s ? sx(v[0]) : 18'h0_0000, c9);
      chk("b1", s ? 18'h0_0000 : sx(v[1]), b1);
      chk("b2", s ? 18'h0_0000 : sx(v[2]), b2);
      chk("b3", s ? 18'h0_0000 : sx(v[3]), b3);
      chk("b4", s ? 18'h0_0000 : sx(v[4]), b4);
    end
  endtask
  task t_readback;
    for (i = 0; i < 5; i = i + 1) begin
      rd(offs[i], v[i][7:0]);
      rd(offs[i] + 15'h0001, {4'h0, v[i][11:8]});
    end
  endtask
  task t_dual;
    begin
      for (i = 0; i < 5; i = i + 1) begin
        v[i] = 12'h3A1 + 12'h2F1 * i[11:0];
        wr(offs[i], v[i][7:0]);
        wr(offs[i] + 15'h0001, {4'hF, v[i][11:8]});
      end
      repeat (2) @(negedge clk);
      chk_outs(1'b0);
      t_readback;
    end
  endtask
  task t_single;
    begin
      single = 1;
      repeat (2) @(negedge clk);
      chk_outs(1'b1);
      single = 0;
      repeat (2) @(negedge clk);
      chk_outs(1'b0);
    end
  endtask
  task t_unmapped;
    begin
      wr(15'h0400, 8'h55);
      rd(15'h0400, 8'h00);
      chk_outs(1'b0);
    end
  endtask
  // mid-run reset: live weights must be clear one cycle after reset asserts and stay clear after release
  task t_reset;
    begin
      @(negedge clk);
      rst_n = 0;
      for (i = 0; i < 5; i = i + 1) begin
        v[i] = 12'h000;
      end
      @(negedge clk);
      chk_outs(1'b0);
      rst_n = 1;
      chk_outs(1'b0);
      t_readback;
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1;
    chk_outs(1'b0);
    t_readback;
    t_dual;
    t_single;
    t_unmapped;
    t_reset;
    tally_and_finish;
  end
endmodule // coef_bank_tb
bind coef_bank coef_bank_chk #(.ADDR_W(ADDR_W), .CENTRE_WIDTH(CENTRE_WIDTH)) coef_bank_chk_inst (.*);
